// >>> logic/sdrv_defines.svh
// Bit positions, codes and reset values of the solenoid driver serial register bank
`ifndef SDRV_DEFINES_SVH
`define SDRV_DEFINES_SVH

`define SDRV_FRAME_BITS 16
`define SDRV_LANE_BIT 15
`define SDRV_OP_HI 14
`define SDRV_OP_LO 13
`define SDRV_EXT_HI 12
`define SDRV_EXT_LO 11
`define SDRV_SEL_HI 10
`define SDRV_SEL_LO 8
`define SDRV_VAL_HI 7
`define SDRV_VAL_LO 0
`define SDRV_OPEN_BIT 12
`define SDRV_BATT_BIT 11
`define SDRV_HEAT_BIT 10
`define SDRV_REF_BIT 6
`define SDRV_FT_BIT 5
`define SDRV_RATE_HI 4
`define SDRV_RATE_LO 3
`define SDRV_HYST_HI 2
`define SDRV_HYST_LO 0
`define SDRV_OP_GENCFG 2'h2
`define SDRV_OP_ERRREAD 2'h3
`define SDRV_EXT_ZERO 2'h0
`define SDRV_FT_RESET 1'h0
`define SDRV_RATE_RESET 2'h3
`define SDRV_HYST_RESET 3'h0
`define SDRV_SEL_RESET 3'h0
`define SDRV_SEL_REVISION 3'h5
`define SDRV_SEL_LAST_CORR 3'h4
`define SDRV_INVALID_WORD 16'h0000

`endif

// >>> logic/sdrv_lane_regs.sv
// Per-lane setting store of the general configuration frame
`timescale 1ns/100ps
`include "sdrv_defines.svh"
module sdrv_lane_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr,
    input wire logic [`SDRV_FRAME_BITS-1:0] word,
    output logic fault_typing_enable,
    output logic [1:0] edge_rate_code,
    output logic [2:0] comparator_hyst_code
);
    // Only B5..B0 are stored; B12..B6 of the write fall away here
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fault_typing_enable <= `SDRV_FT_RESET; // (RULE_01)
            edge_rate_code <= `SDRV_RATE_RESET; // (RULE_02)
            comparator_hyst_code <= `SDRV_HYST_RESET; // (RULE_03)
        end else if (wr) begin
            fault_typing_enable <= word[`SDRV_FT_BIT]; // (RULE_01)
            edge_rate_code <= word[`SDRV_RATE_HI:`SDRV_RATE_LO]; // (RULE_02)
            comparator_hyst_code <= word[`SDRV_HYST_HI:`SDRV_HYST_LO]; // (RULE_03) (RULE_04)
        end
    end
endmodule

// >>> logic/sdrv_pkg.sv
// Types shared by the solenoid driver serial register bank
package sdrv_pkg;
    typedef enum logic [1:0] {
        SDRV_FR_OTHER = 2'h0,
        SDRV_FR_GENCFG = 2'h1,
        SDRV_FR_ERRREAD = 2'h3,
        SDRV_FR_INVALID = 2'h2
    } sdrv_frame_t;

    typedef enum logic [1:0] {
        SDRV_ST_IDLE = 2'h0,
        SDRV_ST_SHIFT = 2'h1,
        SDRV_ST_DONE = 2'h3
    } sdrv_link_t;
endpackage

// >>> logic/sdrv_spi_bank.sv
// Serial register bank of a two-lane solenoid current driver
//
// Operation
// (RULE_01) Config write bit B5 enables fault typing pull-up; resets to 0.
// (RULE_02) Config write B4..B3 is edge rate code; resets to 3.
// (RULE_03) Config write B2..B0 is hysteresis code; resets to 0.
// (RULE_04) Config write bits B12..B6 are ignored.
// (RULE_05) Config response: open/ground B12, battery short B11, overheat B10.
// (RULE_06) Config response bits B9..B7 are always zero.
// (RULE_07) Response B6 is 0 for external reference, 1 for internal.
// (RULE_08) Config response echoes stored enable, edge rate and hysteresis codes.
// (RULE_09) Edge rate codes 0..3 mean 12, 6, 3, 1.2 V/us; drive output stage.
// (RULE_10) Hysteresis codes 0..7 mean 40..110 mVpp; drive the comparator.
// (RULE_11) Master sends error-read extension bits B12..B11 as 00.
// (RULE_12) Error-read selector B10..B8 picks data returned in the next frame.
// (RULE_13) Error-read bits B7..B0 are ignored.
// (RULE_14) Error-read reply: extension 00, selector B10..B8, value B7..B0.
// (RULE_15) Selectors 0..4 correction registers, 5 revision, 6 and 7 zero.
// (RULE_16) Invalid commands X1101, X1110, X1111 never answer FFFF.
// (RULE_17) B15 selects the lane; writes and replies use it, echoed.
`timescale 1ns/100ps
`include "sdrv_defines.svh"
module sdrv_spi_bank #(
    parameter logic [7:0] REVISION_CODE = 8'h5a, // Arbitrary revision value
    parameter logic [7:0] CORR_RESET = 8'h00
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SCLK,
    input wire logic CSN,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    input wire logic [1:0] OPEN_OR_GROUND_FAULT,
    input wire logic [1:0] BATTERY_SHORT_FAULT,
    input wire logic [1:0] OVERHEAT_FAULT,
    input wire logic INTERNAL_REF_ACTIVE,
    input wire logic [1:0] CORR_WE,
    input wire logic [2:0] CORR_INDEX,
    input wire logic [7:0] CORR_DATA,
    output logic [1:0] FAULT_TYPING_ENABLE,
    output logic [3:0] EDGE_RATE_CODE,
    output logic [5:0] COMPARATOR_HYST_CODE
);
    import sdrv_pkg::*;

    localparam int FB = `SDRV_FRAME_BITS;
    localparam int NCORR = 5;

    // ---------- Link domain, clocked by SCLK ----------
    logic [FB-1:0] rx_shift;
    logic [FB-1:0] tx_shift;
    logic [4:0] bit_cnt;
    logic rx_toggle;
    logic tx_started;
    logic [FB-1:0] rx_word;
    logic [FB-1:0] reply_link;

    // Status inputs arrive from analog/other logic and are synchronised on CLK
    logic [1:0] open_s;
    logic [1:0] batt_s;
    logic [1:0] heat_s;
    logic ref_s;

    // ---------- System domain ----------
    logic [2:0] tog_sync;
    logic tog_seen;
    logic frame_done;
    logic [FB-1:0] word_hold;
    logic [FB-1:0] reply;
    logic [FB-1:0] next_reply;
    logic [1:0] cfg_wr;
    logic [1:0] ft;
    logic [1:0] rate [0:1];
    logic [2:0] hyst [0:1];
    logic [7:0] corr [0:1][0:NCORR-1];
    logic [2:0] pend_sel;
    logic pend_lane;
    sdrv_frame_t frame_kind;
    sdrv_link_t link_state;
    logic lane;

    // Receive shift on rising SCLK; frame count restarts whenever select is high.
    // SCLK may stop between frames, so the frame end is flagged from the 16th edge.
    always_ff @(posedge SCLK or posedge CSN) begin
        if (CSN) begin
            bit_cnt <= 5'h00;
        end else begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge SCLK) begin
        rx_shift <= {rx_shift[FB-2:0], MOSI};
    end

    // Full word handed over with a toggle; word stays stable for a whole frame
    always_ff @(posedge SCLK) begin
        if (!CSN && bit_cnt == 5'(FB - 1)) begin
            rx_word <= {rx_shift[FB-2:0], MOSI};
        end
    end

    // Toggle needs a known start; SCLK is idle in reset, so the pin reset clears it
    always_ff @(posedge SCLK or negedge RSTN) begin
        if (!RSTN) begin
            rx_toggle <= 1'b0;
        end else if (!CSN && bit_cnt == 5'(FB - 1)) begin
            rx_toggle <= ~rx_toggle;
        end
    end

    // First falling edge of a frame marks the shifter as loaded
    always_ff @(negedge SCLK or posedge CSN) begin
        if (CSN) begin
            tx_started <= 1'b0;
        end else begin
            tx_started <= 1'b1;
        end
    end

    // Reply is loaded at the first falling edge, not at select rise: the system
    // side finishes the reply only a few cycles after select has gone high.
    always_ff @(negedge SCLK) begin
        if (!tx_started) begin
            tx_shift <= {reply_link[FB-2:0], 1'b0};
        end else begin
            tx_shift <= {tx_shift[FB-2:0], 1'b0};
        end
    end

    // Reply is static between frames, so its top bit can lead the frame directly
    assign reply_link = reply;
    assign MISO = tx_started ? tx_shift[FB-1] : reply_link[FB-1];
    assign MISO_OE = ~CSN;

    // Toggle synchroniser: stage 0 read only by stage 1
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tog_sync <= 3'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], rx_toggle};
        end
    end

    assign frame_done = tog_sync[2] ^ tog_sync[1];

    // Word is stable for many CLK cycles after the toggle edge
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            word_hold <= '0;
            tog_seen <= 1'b0;
        end else begin
            tog_seen <= frame_done;
            if (frame_done) begin
                word_hold <= rx_word;
            end
        end
    end

    sdrv_sync2 #(.WIDTH(7)) u_status_sync (
        .clk(CLK),
        .rstn(RSTN),
        .async_in({OPEN_OR_GROUND_FAULT, BATTERY_SHORT_FAULT, OVERHEAT_FAULT,
                   INTERNAL_REF_ACTIVE}),
        .sync_out({open_s, batt_s, heat_s, ref_s})
    );

    // Decode top five bits of the captured word
    assign lane = word_hold[`SDRV_LANE_BIT]; // (RULE_17)

    always_comb begin
        frame_kind = SDRV_FR_OTHER;
        if (word_hold[`SDRV_OP_HI:`SDRV_OP_LO] == `SDRV_OP_GENCFG) begin
            frame_kind = SDRV_FR_GENCFG;
        end else if (word_hold[`SDRV_OP_HI:`SDRV_OP_LO] == `SDRV_OP_ERRREAD) begin
            if (word_hold[`SDRV_EXT_HI:`SDRV_EXT_LO] == `SDRV_EXT_ZERO) begin
                frame_kind = SDRV_FR_ERRREAD; // (RULE_11)
            end else begin
                frame_kind = SDRV_FR_INVALID; // (RULE_16)
            end
        end
    end

    // Link progress marker for observation
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            link_state <= SDRV_ST_IDLE;
        end else begin
            case (link_state)
                SDRV_ST_IDLE: link_state <= frame_done ? SDRV_ST_SHIFT : SDRV_ST_IDLE;
                SDRV_ST_SHIFT: link_state <= SDRV_ST_DONE;
                SDRV_ST_DONE: link_state <= SDRV_ST_IDLE;
                default: link_state <= SDRV_ST_IDLE;
            endcase
        end
    end

    // Configuration write strobe per lane
    always_comb begin
        cfg_wr = 2'h0;
        if (tog_seen && frame_kind == SDRV_FR_GENCFG) begin
            cfg_wr[lane] = 1'b1; // (RULE_17)
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            sdrv_lane_regs u_regs (
                .clk(CLK),
                .rstn(RSTN),
                .wr(cfg_wr[g]),
                .word(word_hold),
                .fault_typing_enable(ft[g]),
                .edge_rate_code(rate[g]),
                .comparator_hyst_code(hyst[g])
            );
            assign FAULT_TYPING_ENABLE[g] = ft[g]; // (RULE_01)
            assign EDGE_RATE_CODE[2*g+1:2*g] = rate[g]; // (RULE_09)
            assign COMPARATOR_HYST_CODE[3*g+2:3*g] = hyst[g]; // (RULE_10)
        end
    endgenerate

    // Correction registers loaded by trim logic on the same clock
    always_ff @(posedge CLK) begin
        for (int l = 0; l < 2; l++) begin
            for (int i = 0; i < NCORR; i++) begin
                if (!RSTN) begin
                    corr[l][i] <= CORR_RESET;
                end else if (CORR_WE[l] && CORR_INDEX == 3'(i)) begin
                    corr[l][i] <= CORR_DATA;
                end
            end
        end
    end

    // Selector of an error read picks the reply shifted out in the very next frame;
    // the low byte of the request is never looked at
    assign pend_sel = word_hold[`SDRV_SEL_HI:`SDRV_SEL_LO]; // (RULE_12) (RULE_13)
    assign pend_lane = lane; // (RULE_12)

    // Next reply word, built from the frame just received
    always_comb begin
        next_reply = reply;
        case (frame_kind)
            SDRV_FR_GENCFG: begin
                next_reply = '0; // (RULE_06)
                next_reply[`SDRV_LANE_BIT] = lane; // (RULE_17)
                next_reply[`SDRV_OP_HI:`SDRV_OP_LO] = `SDRV_OP_GENCFG;
                next_reply[`SDRV_OPEN_BIT] = open_s[lane]; // (RULE_05)
                next_reply[`SDRV_BATT_BIT] = batt_s[lane]; // (RULE_05)
                next_reply[`SDRV_HEAT_BIT] = heat_s[lane]; // (RULE_05)
                next_reply[`SDRV_REF_BIT] = ref_s; // (RULE_07)
                next_reply[`SDRV_FT_BIT] = word_hold[`SDRV_FT_BIT]; // (RULE_08)
                next_reply[`SDRV_RATE_HI:`SDRV_RATE_LO] =
                    word_hold[`SDRV_RATE_HI:`SDRV_RATE_LO]; // (RULE_08)
                next_reply[`SDRV_HYST_HI:`SDRV_HYST_LO] =
                    word_hold[`SDRV_HYST_HI:`SDRV_HYST_LO]; // (RULE_08)
            end
            SDRV_FR_ERRREAD: begin
                next_reply = '0;
                next_reply[`SDRV_LANE_BIT] = pend_lane; // (RULE_17)
                next_reply[`SDRV_OP_HI:`SDRV_OP_LO] = `SDRV_OP_ERRREAD;
                next_reply[`SDRV_EXT_HI:`SDRV_EXT_LO] = `SDRV_EXT_ZERO; // (RULE_14)
                next_reply[`SDRV_SEL_HI:`SDRV_SEL_LO] = pend_sel; // (RULE_14)
                if (pend_sel <= `SDRV_SEL_LAST_CORR) begin
                    next_reply[`SDRV_VAL_HI:`SDRV_VAL_LO] = corr[pend_lane][pend_sel]; // (RULE_15)
                end else if (pend_sel == `SDRV_SEL_REVISION) begin
                    next_reply[`SDRV_VAL_HI:`SDRV_VAL_LO] = REVISION_CODE; // (RULE_15)
                end
            end
            SDRV_FR_INVALID: next_reply = `SDRV_INVALID_WORD; // (RULE_16)
            default: next_reply = `SDRV_INVALID_WORD; // (RULE_16)
        endcase
    end

    // Reply register; the echo uses the written settings, equal to the stored ones
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            reply <= '0;
        end else if (tog_seen) begin
            reply <= next_reply;
        end
    end
endmodule

// >>> logic/sdrv_sync2.sv
// Two flip-flop level synchroniser, parameterised width
`timescale 1ns/100ps
module sdrv_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// >>> sim/sdrv_master.sv
// Serial bus master model, mode 0, 16-bit frames, lane bit first
`timescale 1ns/100ps
module sdrv_master (
    input wire logic miso,
    output logic sclk,
    output logic csn,
    output logic mosi
);
    int gap = 400;
    // Clock rests low and select high outside frames
    // Select starts low for an instant so the link counter sees its clear
    initial begin
        sclk = 1'b0;
        csn = 1'b0;
        mosi = 1'b0;
        #1;
        csn = 1'b1;
    end
    // One frame; the offset keeps edges clear of the system clock when the call starts on a clock edge
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        #7;
        csn = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = tx[i];
            #40;
            sclk = 1'b1;
            rx[i] = miso;
            #40;
            sclk = 1'b0;
        end
        // Select ends with the last falling edge, a fixed point for the settings delay
        csn = 1'b1;
        mosi = ~mosi; // Released line shows no stale bit
        #(gap);
    endtask
endmodule

// >>> sim/sdrv_spi_bank_asserts.sv
// Port checks of the solenoid driver serial register bank
`timescale 1ns/100ps
module sdrv_chk (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CSN,
    input wire logic MISO_OE,
    input wire logic [1:0] FAULT_TYPING_ENABLE,
    input wire logic [3:0] EDGE_RATE_CODE,
    input wire logic [5:0] COMPARATOR_HYST_CODE
);
    logic [11:0] s;
    logic [5:0] l0;
    logic [5:0] l1;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Settings as a whole and per lane
    assign s = {FAULT_TYPING_ENABLE, EDGE_RATE_CODE, COMPARATOR_HYST_CODE};
    assign l0 = {FAULT_TYPING_ENABLE[0], EDGE_RATE_CODE[1:0], COMPARATOR_HYST_CODE[2:0]};
    assign l1 = {FAULT_TYPING_ENABLE[1], EDGE_RATE_CODE[3:2], COMPARATOR_HYST_CODE[5:3]};
    // A write lands only after the select has been seen high for a while
    sequence quiet3;
        $stable(s)[*3];
    endsequence
    sequence quiet8;
        $stable(s)[*8];
    endsequence
    rst_val_a: assert property ($rose(RSTN) |-> s == 12'h3c0)
        else $error("settings not at reset values");
    oe_idle_a: assert property (CSN |-> !MISO_OE)
        else $error("reply driver on while not selected");
    oe_frame_a: assert property ($fell(CSN) |-> MISO_OE[*8])
        else $error("reply driver off in frame");
    busy_hold_a: assert property (!CSN |-> $stable(s))
        else $error("settings moved during a frame");
    rise_hold_a: assert property ($rose(CSN) |-> quiet3)
        else $error("settings moved too soon after frame");
    lane_sep_a: assert property (!$stable(l0) |-> $stable(l1))
        else $error("one frame changed both lanes");
    upd_hold_a: assert property (!$stable(s) |=> quiet8)
        else $error("settings changed twice in a row");
    upd_idle_a: assert property (!$stable(s) |-> CSN && $past(CSN, 3))
        else $error("settings changed without frame end");
endmodule

bind sdrv_spi_bank sdrv_chk u_chk (.CLK(CLK), .RSTN(RSTN), .CSN(CSN), .MISO_OE(MISO_OE),
    .FAULT_TYPING_ENABLE(FAULT_TYPING_ENABLE), .EDGE_RATE_CODE(EDGE_RATE_CODE),
    .COMPARATOR_HYST_CODE(COMPARATOR_HYST_CODE));

// >>> sim/tb.sv
// Self-checking bench for the solenoid driver serial register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic sclk, csn, mosi, miso;
    logic ref_int = 1'b0;
    logic [1:0] opn = 2'h0, bat = 2'h0, hot = 2'h0, we = 2'h0, fte;
    logic [2:0] idx = 3'h0;
    logic [7:0] dat = 8'h00;
    logic [3:0] erc;
    logic [5:0] hys;
    logic [15:0] rx;
    logic [15:0] exp_q = 16'h0000;
    logic [5:0] set_q [2] = '{6'h18, 6'h18};
    int bad_count = 0;
    int check_count = 0;

    sdrv_master u_m (.miso(miso), .sclk(sclk), .csn(csn), .mosi(mosi));
    sdrv_spi_bank #(.REVISION_CODE(REV)) uut (.CLK(clk), .RSTN(rstn), .SCLK(sclk),
        .CSN(csn), .MOSI(mosi), .MISO(miso), .MISO_OE(), .OPEN_OR_GROUND_FAULT(opn),
        .BATTERY_SHORT_FAULT(bat), .OVERHEAT_FAULT(hot), .INTERNAL_REF_ACTIVE(ref_int),
        .CORR_WE(we), .CORR_INDEX(idx), .CORR_DATA(dat), .FAULT_TYPING_ENABLE(fte),
        .EDGE_RATE_CODE(erc), .COMPARATOR_HYST_CODE(hys));

    initial forever #20 clk = ~clk;

    function automatic logic [5:0] lane_set(input logic l);
        return l ? {fte[1], erc[3:2], hys[5:3]} : {fte[0], erc[1:0], hys[2:0]};
    endfunction

    // Reply of a frame shows up one frame later, so it is judged then
    task automatic frame(input logic [15:0] w, input logic [15:0] e);
        u_m.xfer(w, rx);
        `CHK("reply", exp_q, rx)
        exp_q = e;
    endtask

    task automatic check_lanes();
        `CHK("lane 0 settings", set_q[0], lane_set(1'b0))
        `CHK("lane 1 settings", set_q[1], lane_set(1'b1))
    endtask

    task automatic t_reset();
        `CHK("reset settings", 12'h3c0, {fte, erc, hys})
        frame(16'h0000, 16'h0000);
    endtask

    // Every edge rate and hysteresis code, ignored bits all set
    task automatic t_config();
        logic [5:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {i[1], i[2:1], i[2:0]};
            @(negedge clk);
            opn = i[1:0];
            bat = i[2:1];
            hot = ~i[1:0];
            ref_int = i[0];
            frame({i[0], 2'b10, 7'h7f, v}, {i[0], 2'b10, opn[i[0]], bat[i[0]],
                hot[i[0]], 3'b000, ref_int, v});
            set_q[i[0]] = v;
            check_lanes();
        end
    endtask

    // Every selector on both lanes, ignored bits all set
    task automatic t_errread();
        logic [7:0] v;
        for (int k = 0; k < 10; k++) begin
            @(negedge clk);
            we = 2'h1 << k[0];
            idx = k[3:1];
            dat = 8'h40 + k[7:0];
        end
        @(negedge clk);
        we = 2'h0;
        for (int k = 0; k < 16; k++) begin
            v = (k < 10) ? 8'h40 + k[7:0] : (k < 12) ? REV : 8'h00;
            frame({k[0], 2'b11, 2'b00, k[3:1], 8'hff}, {k[0], 4'hc, k[3:1], v});
        end
        check_lanes();
    endtask

    // Invalid and unused commands answer zero and change nothing
    task automatic t_invalid();
        for (int k = 1; k < 4; k++) begin
            frame({1'b1, 2'b11, k[1:0], 11'h7ff}, 16'h0000);
        end
        frame(16'h3fff, 16'h0000);
        frame(16'h0000, 16'h0000);
        check_lanes();
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        results();
    end

    // Reset falls after time zero so the link toggle sees a real reset edge
    initial begin
        #1;
        rstn = 1'b0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_config();
        t_errread();
        t_invalid();
        results();
    end
endmodule
